// [mapr_map.vh]
// Purpose: register map and constants for the station address / pause time block
// Assumes: 32-bit AXI4-Lite register bus, 10 MHz clock
// Notes: offsets are byte addresses of aligned words
`ifndef MAPR_MAP_VH
`define MAPR_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MAPR_ADDR_W 4
`define MAPR_OFS_ADDR_LOW 4'h0
`define MAPR_OFS_PAUSE_TIME 4'h4
`define MAPR_OFS_PAUSE_CTRL 4'h8
`define MAPR_OFS_PAUSE_STAT 4'hC

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define MAPR_FIELD_MSB 15
`define MAPR_RST_ADDR_LOW 16'h0000
`define MAPR_RST_PAUSE_TIME 16'h0000
`define MAPR_RESP_OKAY 2'h0
`define MAPR_RESP_SLVERR 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define MAPR_QUANTA_BITS 512
`define MAPR_LINK_MBPS 100
`define MAPR_CLK_MHZ 10
// Clock cycles per pause quantum: bits / Mbit/s gives us, times MHz gives cycles
`define MAPR_QUANTA_CYC ((`MAPR_QUANTA_BITS * `MAPR_CLK_MHZ + `MAPR_LINK_MBPS - 1) / `MAPR_LINK_MBPS)
`define MAPR_QCNT_W 8

`endif

// [mapr_pause_frame.v]
// Purpose: serialises the pause control parameter octets and paces one quantum
// Assumes: octet consumer accepts one octet per cycle while ready is high
// Notes: operands are latched at start, so register writes mid-frame have no effect
`timescale 1ns/1ps
`default_nettype none
`include "mapr_map.vh"

module mapr_pause_frame (
	input wire aclk, // Clock
	input wire aresetn, // Sync reset, active low
	input wire start, // Pulse: send pause parameter
	input wire [15:0] pause_time, // Pause time in quanta
	input wire octet_ready, // Consumer accepts octet
	output reg octet_valid, // Octet valid
	output reg [7:0] octet_data, // Octet data
	output wire busy, // Frame in progress
	output reg quantum_tick // Pulse every 52 clocks (512 bit times rounded up to whole cycles)
);
	localparam ST_IDLE = 3'b001;
	localparam ST_HI = 3'b010;
	localparam ST_LO = 3'b100;

	reg [2:0] state_q;
	reg [15:0] time_q;
	reg [`MAPR_QCNT_W-1:0] qcnt_q;

	assign busy = (state_q != ST_IDLE);

	// ----------------------------------------
	// Octet sequencer, high octet first
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_IDLE;
			time_q <= `MAPR_RST_PAUSE_TIME;
			octet_valid <= 1'b0;
			octet_data <= 8'h00;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						time_q <= pause_time;
						octet_data <= pause_time[15:8];
						octet_valid <= 1'b1;
						state_q <= ST_HI;
					end
				end
				ST_HI: begin
					if (octet_ready) begin
						octet_data <= time_q[7:0];
						state_q <= ST_LO;
					end
				end
				ST_LO: begin
					if (octet_ready) begin
						octet_valid <= 1'b0;
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					octet_valid <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Quantum pacing
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			qcnt_q <= {`MAPR_QCNT_W{1'b0}};
			quantum_tick <= 1'b0;
		end else if (qcnt_q == `MAPR_QUANTA_CYC - 1) begin
			qcnt_q <= {`MAPR_QCNT_W{1'b0}};
			quantum_tick <= 1'b1;
		end else begin
			qcnt_q <= qcnt_q + 1'b1;
			quantum_tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [mapr_regs.v]
// Purpose: station address low and automatic pause time registers on AXI4-Lite
// Assumes: software programs the address only while tx and rx are disabled
// Assumes: pause requests are single-cycle pulses in the aclk domain
// Notes: upper 16 bits of each register except 0xC read as zero and ignore writes; 0xC carries the sent count there
// Notes: 0x8 bit 0 asks for a pause send; 0xC reports count, pending and busy
// Notes: a pause send is two octets, time high byte first, paced by ready
`timescale 1ns/1ps
`default_nettype none
`include "mapr_map.vh"

module mapr_regs (
	input wire aclk, // Clock, 10 MHz
	input wire aresetn, // Sync reset, active low
	input wire [`MAPR_ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	output wire s_axi_awready, // Write address ready
	input wire [31:0] s_axi_wdata, // Write data
	input wire [3:0] s_axi_wstrb, // Write strobes
	input wire s_axi_wvalid, // Write data valid
	output wire s_axi_wready, // Write data ready
	output reg [1:0] s_axi_bresp, // Write response
	output reg s_axi_bvalid, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire [`MAPR_ADDR_W-1:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	output wire s_axi_arready, // Read address ready
	output reg [31:0] s_axi_rdata, // Read data
	output reg [1:0] s_axi_rresp, // Read response
	output reg s_axi_rvalid, // Read data valid
	input wire s_axi_rready, // Read data ready
	input wire pause_request, // Pulse: flow control wants a pause frame
	output wire [15:0] station_addr_low, // Octets five and six of address
	input wire octet_ready, // Consumer accepts octet
	output wire octet_valid, // Pause parameter octet valid
	output wire [7:0] octet_data, // Pause parameter octet
	output wire quantum_tick // Pulse every pause quantum
);
	reg [15:0] addr_low_q;
	reg [15:0] pause_time_q;
	reg aw_held_q;
	reg w_held_q;
	reg [`MAPR_ADDR_W-1:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg pend_q;
	reg [15:0] sent_cnt_q;
	wire busy;
	wire do_write;
	wire sw_start;
	wire start;
	wire [`MAPR_ADDR_W-1:0] waddr;
	wire [31:0] wdata;
	wire [3:0] wstrb;
	wire wr_addr_low;
	wire wr_pause_time;
	wire wr_pause_ctrl;
	wire [1:0] addr_lane_we;
	wire [1:0] pause_lane_we;
	wire [15:0] addr_low_d;
	wire [15:0] pause_time_d;
	reg [31:0] rdata_d;
	reg [1:0] rresp_d;

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	// Hold address and data apart so either may arrive first
	// A pending response holds both readys low, so writes never overlap
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	assign waddr = aw_held_q ? awaddr_q : s_axi_awaddr;
	assign wdata = w_held_q ? wdata_q : s_axi_wdata;
	assign wstrb = w_held_q ? wstrb_q : s_axi_wstrb;
	assign do_write = !s_axi_bvalid && (aw_held_q || s_axi_awvalid) && (w_held_q || s_axi_wvalid);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= {`MAPR_ADDR_W{1'b0}};
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `MAPR_RESP_OKAY;
		end else begin
			if (do_write) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (waddr)
					`MAPR_OFS_ADDR_LOW, `MAPR_OFS_PAUSE_TIME,
					`MAPR_OFS_PAUSE_CTRL, `MAPR_OFS_PAUSE_STAT:
						s_axi_bresp <= `MAPR_RESP_OKAY;
					default: s_axi_bresp <= `MAPR_RESP_SLVERR;
				endcase
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held_q <= 1'b1;
					awaddr_q <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held_q <= 1'b1;
					wdata_q <= s_axi_wdata;
					wstrb_q <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Only the low two byte lanes exist; upper lanes are dropped
	assign wr_addr_low = do_write && (waddr == `MAPR_OFS_ADDR_LOW);
	assign wr_pause_time = do_write && (waddr == `MAPR_OFS_PAUSE_TIME);
	assign wr_pause_ctrl = do_write && (waddr == `MAPR_OFS_PAUSE_CTRL);

	genvar lane;
	generate
		for (lane = 0; lane < 2; lane = lane + 1) begin : g_lane
			// Each lane keeps its byte unless its strobe is set
			assign addr_lane_we[lane] = wr_addr_low && wstrb[lane];
			assign pause_lane_we[lane] = wr_pause_time && wstrb[lane];
			assign addr_low_d[lane*8 +: 8] = addr_lane_we[lane] ?
				wdata[lane*8 +: 8] : addr_low_q[lane*8 +: 8];
			assign pause_time_d[lane*8 +: 8] = pause_lane_we[lane] ?
				wdata[lane*8 +: 8] : pause_time_q[lane*8 +: 8];
		end
	endgenerate

	always @(posedge aclk) begin
		if (!aresetn) begin
			addr_low_q <= `MAPR_RST_ADDR_LOW;
			pause_time_q <= `MAPR_RST_PAUSE_TIME;
		end else begin
			addr_low_q <= addr_low_d;
			pause_time_q <= pause_time_d;
		end
	end

	assign station_addr_low = addr_low_q;

	// ----------------------------------------
	// Pause frame trigger and status
	// ----------------------------------------
	// Software may also request a frame via bit 0 of the control word
	// Requests made during a send merge into one pending flag
	assign sw_start = wr_pause_ctrl && wstrb[0] && wdata[0];
	assign start = pend_q && !busy;

	always @(posedge aclk) begin
		if (!aresetn) begin
			pend_q <= 1'b0;
			sent_cnt_q <= 16'h0000;
		end else begin
			// New request wins over the launch of an older one
			if (pause_request || sw_start)
				pend_q <= 1'b1;
			else if (start)
				pend_q <= 1'b0;
			if (start)
				sent_cnt_q <= sent_cnt_q + 16'h0001;
		end
	end

	mapr_pause_frame u_frame (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(start),
		.pause_time(pause_time_q),
		.octet_ready(octet_ready),
		.octet_valid(octet_valid),
		.octet_data(octet_data),
		.busy(busy),
		.quantum_tick(quantum_tick)
	);

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	// One read in flight; the answer follows the next cycle
	assign s_axi_arready = !s_axi_rvalid;

	always @* begin
		rdata_d = 32'h00000000;
		rresp_d = `MAPR_RESP_OKAY;
		case (s_axi_araddr)
			`MAPR_OFS_ADDR_LOW: rdata_d = {16'h0000, addr_low_q};
			`MAPR_OFS_PAUSE_TIME: rdata_d = {16'h0000, pause_time_q};
			// Control word reads zero; its bit 0 only launches a send
			`MAPR_OFS_PAUSE_CTRL: rdata_d = 32'h00000000;
			`MAPR_OFS_PAUSE_STAT: rdata_d = {sent_cnt_q, 14'h0000, pend_q, busy};
			default: rresp_d = `MAPR_RESP_SLVERR;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `MAPR_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdata_d;
			s_axi_rresp <= rresp_d;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [mapr_regs_properties.sv]
// Purpose: port checks for mapr_regs
// Assumes: one write and one read under way at a time
// Notes: the pause value itself is judged by the bench
`timescale 1ns/1ps
`default_nettype none
`include "mapr_map.vh"

module mapr_regs_chk (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, low
	input wire logic [`MAPR_ADDR_W-1:0] s_axi_awaddr, // Wr addr
	input wire logic s_axi_awvalid, // Wr addr valid
	input wire logic s_axi_awready, // Wr addr ready
	input wire logic [31:0] s_axi_wdata, // Wr data
	input wire logic [3:0] s_axi_wstrb, // Strobes
	input wire logic s_axi_wvalid, // Wr data valid
	input wire logic s_axi_wready, // Wr data ready
	input wire logic s_axi_bvalid, // Wr resp valid
	input wire logic [`MAPR_ADDR_W-1:0] s_axi_araddr, // Rd addr
	input wire logic s_axi_arvalid, // Rd addr valid
	input wire logic s_axi_arready, // Rd addr ready
	input wire logic [31:0] s_axi_rdata, // Rd data
	input wire logic s_axi_rvalid, // Rd data valid
	input wire logic [15:0] station_addr_low, // Address pins
	input wire logic octet_ready, // Octet accept
	input wire logic octet_valid, // Octet valid
	input wire logic [7:0] octet_data, // Octet
	input wire logic quantum_tick // Quantum pulse
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [`MAPR_ADDR_W-1:0] ra_q;
	wire aw_t = s_axi_awvalid && s_axi_awready;
	wire w_t = s_axi_wvalid && s_axi_wready;
	// Status word at 0xC carries a count up high, so only the two low words
	always @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready)
			ra_q <= s_axi_araddr;
	end
	sequence s_hi_taken;
		$rose(octet_valid) && octet_ready;
	endsequence
	property p_addr_wr;
		aw_t && w_t && s_axi_awaddr == 4'h0 && s_axi_wstrb[1:0] == 2'h3
			|=> {16'h0, station_addr_low} == ($past(s_axi_wdata) & 32'hFFFF);
	endproperty
	a_addr_wr: assert property (p_addr_wr) else $error("address write lost");
	property p_rd_hi;
		s_axi_rvalid && !ra_q[3] |-> s_axi_rdata[31:16] == 16'h0;
	endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("upper bits not zero");
	property p_rd_ans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_wr_ans;
		aw_t && w_t |=> s_axi_bvalid;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
	property p_tick;
		quantum_tick |-> ##52 quantum_tick;
	endproperty
	a_tick: assert property (p_tick) else $error("quantum period wrong");
	property p_second;
		s_hi_taken |=> octet_valid;
	endproperty
	a_second: assert property (p_second) else $error("low octet missing");
	property p_oct_hold;
		octet_valid && !octet_ready |=> octet_valid && $stable(octet_data);
	endproperty
	a_oct_hold: assert property (p_oct_hold) else $error("octet dropped");
endmodule

bind mapr_regs mapr_regs_chk u_chk (.*);
`default_nettype wire

// [mapr_link_model.sv]
// Purpose: far station taking pause parameter octets
// Assumes: octets arrive high first
// Notes: slow mode accepts every other cycle
`timescale 1ns/1ps
`default_nettype none

module mapr_link_model (
	input wire logic aclk, // Clock
	input wire logic slow, // Stall mode
	input wire logic octet_valid, // Octet valid
	input wire logic [7:0] octet_data, // Octet
	output logic octet_ready, // Accept
	output logic [15:0] time_seen // Last TIME
);
	logic ph_q = 1'h0;
	always @(posedge aclk) begin
		ph_q <= ~ph_q;
		if (octet_valid && octet_ready)
			time_seen <= {time_seen[7:0], octet_data};
	end
	assign octet_ready = !slow || ph_q;
endmodule
`default_nettype wire

// [mapr_regs_tb_top.sv]
// Purpose: register and pause checks for mapr_regs
// Assumes: bus answers within 40 cycles
// Notes: one frame prompt, one with the far side stalling
`timescale 1ns/1ps
`default_nettype none

module mapr_regs_tb_top;
	logic aclk = 1'h0, aresetn = 1'h0, slow = 1'h0, pause_request = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [15:0] station_addr_low, time_seen;
	wire logic octet_ready, octet_valid, quantum_tick;
	wire logic [7:0] octet_data;
	int fails = 0, tests_run = 0, n;

	mapr_regs DUT (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.pause_request(pause_request),
		.station_addr_low(station_addr_low),
		.octet_ready(octet_ready),
		.octet_valid(octet_valid),
		.octet_data(octet_data),
		.quantum_tick(quantum_tick)
	);
	mapr_link_model u_far (.aclk(aclk), .slow(slow), .octet_valid(octet_valid),
		.octet_data(octet_data), .octet_ready(octet_ready), .time_seen(time_seen));
	always #50 aclk = ~aclk;

	task end_sim;
		if (fails == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	task guard(input logic ok);
		if (ok !== 1'b1) begin
			fails++;
			end_sim;
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		int k;
		logic ta, tw, tb;
		logic [1:0] r;
		k = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(negedge aclk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'h0;
			if (tw)
				s_axi_wvalid <= 1'h0;
			k++;
		end while (!tb && k < 40);
		s_axi_bready <= 1'h0;
		guard(tb);
		chk("write resp", {30'h0, er}, {30'h0, r});
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
		int k;
		logic ta, t;
		logic [31:0] d;
		logic [1:0] r;
		k = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(negedge aclk);
			ta = s_axi_arready;
			t = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta)
				s_axi_arvalid <= 1'h0;
			k++;
		end while (!t && k < 40);
		s_axi_rready <= 1'h0;
		guard(t);
		chk("read resp", {30'h0, er}, {30'h0, r});
		chk("read data", e, d);
	endtask
	// Waits for one whole frame: valid up, then down again
	task frame(input logic [15:0] e);
		int k;
		k = 0;
		do begin
			@(negedge aclk);
			k++;
		end while (!octet_valid && k < 40);
		do begin
			@(negedge aclk);
			k++;
		end while (octet_valid && k < 40);
		guard(k < 40);
		chk("pause time", {16'h0, e}, {16'h0, time_seen});
	endtask

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		rd(4'h0, 32'h0, 2'h0);
		rd(4'h4, 32'h0, 2'h0);
		wr(4'h0, 32'h89AB, 4'hF, 2'h0);
		rd(4'h0, 32'h89AB, 2'h0);
		chk("address pins", 32'h89AB, {16'h0, station_addr_low});
		wr(4'h0, 32'h12, 4'h1, 2'h0);
		rd(4'h0, 32'h8912, 2'h0);
		wr(4'h4, 32'h1234, 4'hF, 2'h0);
		rd(4'h4, 32'h1234, 2'h0);
		wr(4'h2, 32'h5555, 4'hF, 2'h2);
		rd(4'h2, 32'h0, 2'h2);
		rd(4'h0, 32'h8912, 2'h0);
		@(posedge aclk);
		pause_request <= 1'h1;
		@(posedge aclk);
		pause_request <= 1'h0;
		frame(16'h1234);
		@(posedge aclk);
		slow <= 1'h1;
		wr(4'h4, 32'hA55A, 4'h3, 2'h0);
		wr(4'h8, 32'h1, 4'hF, 2'h0);
		frame(16'hA55A);
		rd(4'hC, 32'h20000, 2'h0);
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		rd(4'h0, 32'h0, 2'h0);
		rd(4'hC, 32'h0, 2'h0);
		wr(4'h0, 32'h4567, 4'h3, 2'h0);
		rd(4'h0, 32'h4567, 2'h0);
		@(negedge aclk);
		for (n = 0; n < 60 && !quantum_tick; n++)
			@(negedge aclk);
		@(negedge aclk);
		for (n = 1; n < 60 && !quantum_tick; n++)
			@(negedge aclk);
		chk("quantum period", 32'h34, n);
		end_sim;
	end
endmodule
`default_nettype wire
